/* verilog/fpl_pkg.sv */
// Constants for the front panel indicator driver.
// Assumes one 20 MHz clock shared by every block of the driver.
`default_nettype none
package fpl_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_USER = 12'h004;
  localparam logic [11:0] OFF_ERRC = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_IRQS = 12'h010;
  localparam logic [11:0] OFF_IRQM = 12'h014;
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_ERR_BIT = 3;
  localparam logic [2:0] CTRL_RST = 3'h1;
  // Status register field positions.
  localparam int STAT_ACT_BIT = 0;
  localparam int STAT_OUT_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_LNK_BIT = 3;
  localparam int STAT_BLK_BIT = 4;
  // Interrupt bits.
  localparam int IRQ_W = 3;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_LINK_BIT = 2;
  // Operational modes, encoded in the control register.
  localparam logic [2:0] MODE_READY = 3'h0;
  localparam logic [2:0] MODE_BOOT = 3'h1;
  localparam logic [2:0] MODE_UPD = 3'h2;
  localparam logic [2:0] MODE_DONE = 3'h3;
  localparam logic [2:0] MODE_NOFW = 3'h4;
  localparam logic [2:0] MODE_RUN = 3'h5;
  // Timing.
  localparam int CLK_HZ = 20000000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int ACT_HOLD_MS = 30;
  localparam int ACT_HOLD_CYC = CLK_HZ / 1000 * ACT_HOLD_MS;
endpackage
`default_nettype wire

/* verilog/fpl_blinker.sv */
// Free running divider that yields a square wave phase.
// Assumes a synchronous clock enable from the parent.
`timescale 1ns/1ps
`default_nettype none
module fpl_blinker #(
  parameter int HALF_CYC = 5000000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Phase out.
  output logic phase
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic phase_ff;
  logic nxt_phase;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_phase = phase_ff;
    if (clk_en) begin
      if (cnt_ff >= 32'(HALF_CYC - 1)) begin
        nxt_cnt = 32'h0;
        nxt_phase = ~phase_ff;
      end else begin
        nxt_cnt = cnt_ff + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
      phase_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      phase_ff <= nxt_phase;
    end
  end

  assign phase = phase_ff;
endmodule
`default_nettype wire

/* verilog/fpl_stretch.sv */
// Pulse stretcher: output stays high for HOLD cycles after the last pulse.
// Assumes input pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module fpl_stretch #(
  parameter int HOLD = 600000
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Trigger and stretched level.
  input wire logic trig,
  output logic busy
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clk_en) begin
      if (trig) begin
        nxt_cnt = 32'(HOLD);
      end else if (cnt_ff != 32'h0) begin
        nxt_cnt = cnt_ff - 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != 32'h0);
endmodule
`default_nettype wire

/* verilog/fpl_top.sv */
// Front panel indicator driver with an APB register file.
// Assumes all inputs are synchronous to pclk.
// Functional notes
// RULE_01 - Channel indicators follow digital channel states
// RULE_02 - CAN indicator follows transmit data, else dark
// RULE_03 - Outputs indicator lit only under application control
// RULE_04 - User indicators application driven when ready, no error; code drives them only in MODE_RUN, forced off in MODE_READY
// RULE_05 - Error lit; indicators one to three show code; code shows it only in MODE_RUN and MODE_READY
// RULE_06 - Link lit, blinks on traffic; speed means 100M
// RULE_07 - Ready: one to three and error off
// RULE_08 - Booting: indicator one lit, others off
// RULE_09 - Updating: one, two lit; three blinks
// RULE_10 - Update finished: one to three blink together
// RULE_11 - No firmware: one and error lit
// RULE_12 - Blink period is a parameter, common divider
`timescale 1ns/1ps
`default_nettype none
module fpl_top #(
  parameter int BLINK_HALF_CYC = fpl_pkg::BLINK_HALF_CYC,
  parameter int ACT_HOLD_CYC = fpl_pkg::ACT_HOLD_CYC
) (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System inputs.
  input wire logic [3:0] dio_state,
  input wire logic can_tx_data,
  input wire logic can_tx_active,
  input wire logic app_outputs_ctrl,
  input wire logic eth_link_pulse,
  input wire logic eth_activity,
  input wire logic eth_speed_100,
  // Indicator outputs.
  output logic digital_channel_indicator_1,
  output logic digital_channel_indicator_2,
  output logic digital_channel_indicator_3,
  output logic digital_channel_indicator_4,
  output logic can_indicator,
  output logic outputs_enabled_indicator,
  output logic user_indicator_1,
  output logic user_indicator_2,
  output logic user_indicator_3,
  output logic user_indicator_4,
  output logic error_indicator,
  output logic link_indicator,
  output logic speed_indicator,
  // Interrupt.
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic blink;
  logic act_busy;
  logic [2:0] mode_ff, nxt_mode;
  logic err_ff, nxt_err;
  logic [3:0] user_ff, nxt_user;
  logic [2:0] errc_ff, nxt_errc;
  logic [fpl_pkg::IRQ_W-1:0] irqs_ff, nxt_irqs, irqm_ff, nxt_irqm;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic prev_link_ff, prev_err_ff, prev_done_ff;
  logic [12:0] led_ff, nxt_led;
  logic irq_ff, nxt_irq;
  logic acc, wr, hit;
  logic [fpl_pkg::IRQ_W-1:0] ev;
  logic running;

  // One divider feeds every blinking indicator so they stay in phase.
  fpl_blinker #(.HALF_CYC(BLINK_HALF_CYC)) u_blink ( // RULE_12
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .phase(blink)
  );

  // Activity is stretched so that short bursts are visible.
  fpl_stretch #(.HOLD(ACT_HOLD_CYC)) u_act (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .trig(eth_activity),
    .busy(act_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file. Each access takes one wait state, and a write lands on
  // the edge that samples pready high so an unfinished access changes nothing.
  assign acc = psel && penable && !pready_ff;
  assign wr = psel && penable && pready_ff && pwrite;
  assign running = (mode_ff == fpl_pkg::MODE_RUN) ||
                   (mode_ff == fpl_pkg::MODE_READY);

  always_comb begin
    ev = '0;
    ev[fpl_pkg::IRQ_ERR_BIT] = err_ff && !prev_err_ff;
    ev[fpl_pkg::IRQ_DONE_BIT] = (mode_ff == fpl_pkg::MODE_DONE) &&
                                !prev_done_ff;
    ev[fpl_pkg::IRQ_LINK_BIT] = eth_link_pulse != prev_link_ff;
  end

  always_comb begin
    nxt_mode = mode_ff;
    nxt_err = err_ff;
    nxt_user = user_ff;
    nxt_errc = errc_ff;
    nxt_irqm = irqm_ff;
    nxt_irqs = irqs_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    hit = 1'b1;
    if (acc) begin
      nxt_pready = 1'b1;
      case (paddr)
        fpl_pkg::OFF_CTRL: nxt_prdata = {28'h0, err_ff, mode_ff};
        fpl_pkg::OFF_USER: nxt_prdata = {28'h0, user_ff};
        fpl_pkg::OFF_ERRC: nxt_prdata = {29'h0, errc_ff};
        fpl_pkg::OFF_STAT: nxt_prdata = {27'h0, blink, eth_link_pulse,
                                         err_ff, app_outputs_ctrl,
                                         running};
        fpl_pkg::OFF_IRQS: nxt_prdata = {29'h0, irqs_ff};
        fpl_pkg::OFF_IRQM: nxt_prdata = {29'h0, irqm_ff};
        default: begin
          hit = 1'b0;
          nxt_prdata = 32'h0;
        end
      endcase
      nxt_pslverr = !hit;
      if (pwrite) begin
        nxt_prdata = 32'h0;
      end
    end
    if (wr) begin
      case (paddr)
        fpl_pkg::OFF_CTRL: begin
          nxt_mode = pwdata[fpl_pkg::CTRL_MODE_LSB +: fpl_pkg::CTRL_MODE_W];
          nxt_err = pwdata[fpl_pkg::CTRL_ERR_BIT];
        end
        fpl_pkg::OFF_USER: nxt_user = pwdata[3:0];
        fpl_pkg::OFF_ERRC: nxt_errc = pwdata[2:0];
        fpl_pkg::OFF_IRQS: nxt_irqs = irqs_ff & ~pwdata[2:0];
        fpl_pkg::OFF_IRQM: nxt_irqm = pwdata[2:0];
        default: nxt_irqm = irqm_ff;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    nxt_irqs = nxt_irqs | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator pattern; bit order is the output port order.
  always_comb begin
    nxt_led = '0;
    nxt_led[3:0] = dio_state; // RULE_01
    nxt_led[4] = can_tx_active && can_tx_data; // RULE_02
    nxt_led[5] = app_outputs_ctrl && running; // RULE_03
    nxt_led[11] = eth_link_pulse && !(act_busy && blink); // RULE_06
    nxt_led[12] = eth_speed_100; // RULE_06
    if (err_ff && running) begin
      nxt_led[10] = 1'b1; // RULE_05
      nxt_led[8:6] = errc_ff; // RULE_05
    end else begin
      case (mode_ff)
        fpl_pkg::MODE_READY: nxt_led[10:6] = 5'h0; // RULE_07
        fpl_pkg::MODE_RUN: nxt_led[9:6] = user_ff; // RULE_04
        fpl_pkg::MODE_BOOT: nxt_led[10:6] = 5'h01; // RULE_08
        fpl_pkg::MODE_UPD: nxt_led[10:6] = {2'h0, blink, 2'h3}; // RULE_09
        fpl_pkg::MODE_DONE: nxt_led[8:6] = {3{blink}}; // RULE_10
        fpl_pkg::MODE_NOFW: nxt_led[10:6] = 5'h11; // RULE_11
        default: nxt_led[10:6] = 5'h0;
      endcase
    end
    nxt_irq = |(nxt_irqs & irqm_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= fpl_pkg::CTRL_RST;
      err_ff <= 1'b0;
      user_ff <= 4'h0;
      errc_ff <= 3'h0;
      irqs_ff <= '0;
      irqm_ff <= '0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prev_link_ff <= 1'b0;
      prev_err_ff <= 1'b0;
      prev_done_ff <= 1'b0;
      led_ff <= '0;
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      mode_ff <= nxt_mode;
      err_ff <= nxt_err;
      user_ff <= nxt_user;
      errc_ff <= nxt_errc;
      irqs_ff <= nxt_irqs;
      irqm_ff <= nxt_irqm;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prev_link_ff <= eth_link_pulse;
      prev_err_ff <= err_ff;
      prev_done_ff <= (mode_ff == fpl_pkg::MODE_DONE);
      led_ff <= nxt_led;
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign digital_channel_indicator_1 = led_ff[0];
  assign digital_channel_indicator_2 = led_ff[1];
  assign digital_channel_indicator_3 = led_ff[2];
  assign digital_channel_indicator_4 = led_ff[3];
  assign can_indicator = led_ff[4];
  assign outputs_enabled_indicator = led_ff[5];
  assign user_indicator_1 = led_ff[6];
  assign user_indicator_2 = led_ff[7];
  assign user_indicator_3 = led_ff[8];
  assign user_indicator_4 = led_ff[9];
  assign error_indicator = led_ff[10];
  assign link_indicator = led_ff[11];
  assign speed_indicator = led_ff[12];

  ////////////////////////////////////////////////////////////////////////////
  a_chan_follow: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> led_ff[3:0] == $past(dio_state))
    else $error("channel indicators lag inputs");
  a_can_dark: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    clk_en && !can_tx_active |=> !can_indicator)
    else $error("can indicator lit while idle");
  a_outputs_enabled_indicator_ctrl: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    clk_en && !app_outputs_ctrl |=> !outputs_enabled_indicator)
    else $error("outputs indicator lit without control");
  a_user_run: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_RUN && !err_ff
    |=> led_ff[9:6] == $past(user_ff))
    else $error("user indicators not application driven");
  a_err_dark: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    clk_en && !err_ff && mode_ff != fpl_pkg::MODE_NOFW
    |=> !error_indicator)
    else $error("error indicator lit without error");
  a_err_code: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    clk_en && err_ff && running
    |=> error_indicator && led_ff[8:6] == $past(errc_ff))
    else $error("error code not shown");
  a_speed_map: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> speed_indicator == $past(eth_speed_100))
    else $error("speed indicator wrong");
  a_link_dark: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    clk_en && !eth_link_pulse |=> !link_indicator)
    else $error("link indicator lit without link");
  a_link_lit: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    clk_en && eth_link_pulse && !act_busy |=> link_indicator)
    else $error("link indicator dark on idle link");
  a_ready_off: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_READY && !err_ff
    |=> led_ff[10:6] == 5'h0)
    else $error("ready pattern wrong");
  a_boot_pat: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_BOOT
    |=> led_ff[10:6] == 5'h01)
    else $error("boot pattern wrong");
  a_upd_pat: assert property ( // RULE_09
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_UPD
    |=> led_ff[7:6] == 2'h3 && !error_indicator
        && user_indicator_3 == $past(blink))
    else $error("update pattern wrong");
  a_done_pat: assert property ( // RULE_10
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_DONE
    |=> led_ff[8:6] == {3{$past(blink)}})
    else $error("done pattern wrong");
  a_nofw_pat: assert property ( // RULE_11
    @(posedge pclk) disable iff (!presetn)
    clk_en && mode_ff == fpl_pkg::MODE_NOFW
    |=> led_ff[10:6] == 5'h11)
    else $error("no firmware pattern wrong");
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && pready |=> !pready)
    else $error("bus ready held for two cycles");
endmodule
`default_nettype wire

/* test/fpl_led_panel.sv */
// Lamp model of the front panel: shows lit lamps and counts lamp changes.
// Assumes active high indicator lines in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module fpl_led_panel (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Indicator lines, channel lamp 1 in bit 0.
  input wire logic [12:0] drive,
  // Lamp state and change counts of user lamps 1 to 3 and link.
  output logic [12:0] lit,
  output logic [3:0][7:0] flips
);
  logic [3:0] watch;
  logic [3:0] last_ff;
  assign lit = drive;
  assign watch = {drive[11], drive[8:6]};
  // Counting changes lets blinking be judged without guessing its phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= 4'h0;
      flips <= '0;
    end else begin
      last_ff <= watch;
      for (int i = 0; i < 4; i++) begin
        if (watch[i] != last_ff[i]) begin
          flips[i] <= flips[i] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the front panel indicator driver.
// Assumes fpl_pkg, the design and the lamp model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, u, c, a;
  logic [3:0] dio_state;
  logic can_tx_data, can_tx_active, app_outputs_ctrl;
  logic eth_link_pulse, eth_activity, eth_speed_100;
  wire [12:0] drive;
  logic [12:0] lit;
  logic [3:0][7:0] flips, f0;
  logic [32:0] expq[$];
  logic [32:0] e;
  logic [2:0] mode [3];
  logic [3:0] pat [3];
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  fpl_top #(.BLINK_HALF_CYC(4), .ACT_HOLD_CYC(8)) i_fpl_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dio_state(dio_state), .can_tx_data(can_tx_data),
    .can_tx_active(can_tx_active), .app_outputs_ctrl(app_outputs_ctrl),
    .eth_link_pulse(eth_link_pulse), .eth_activity(eth_activity),
    .eth_speed_100(eth_speed_100),
    .digital_channel_indicator_1(drive[0]),
    .digital_channel_indicator_2(drive[1]),
    .digital_channel_indicator_3(drive[2]),
    .digital_channel_indicator_4(drive[3]),
    .can_indicator(drive[4]), .outputs_enabled_indicator(drive[5]),
    .user_indicator_1(drive[6]), .user_indicator_2(drive[7]),
    .user_indicator_3(drive[8]), .user_indicator_4(drive[9]),
    .error_indicator(drive[10]), .link_indicator(drive[11]),
    .speed_indicator(drive[12]), .irq(irq));

  fpl_led_panel i_fpl_led_panel (.pclk(pclk), .presetn(presetn),
    .drive(drive), .lit(lit), .flips(flips));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The request is held until pready is sampled high, then released.
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d, input logic [32:0] ex);
    expq.push_back(ex);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is sampled high; nothing but the bench timeout bounds this wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [32:0] ex);
    apb(1'b0, ad, 32'h0, ex);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        fails++;
        $display("ERROR %0t: answer with nothing pending", $time);
      end else begin
        e = expq.pop_front();
        check(prdata, e[31:0]);
        check(32'(pslverr), 32'(e[32]));
      end
    end
  end

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dio_state, can_tx_data, can_tx_active, app_outputs_ctrl} = '0;
    {eth_link_pulse, eth_activity, eth_speed_100} = '0;
    clk_en = 1'b1;
    mode = '{fpl_pkg::MODE_READY, fpl_pkg::MODE_BOOT, fpl_pkg::MODE_NOFW};
    pat = '{4'h0, 4'h1, 4'h9};
    void'($urandom(64));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    check(32'(lit[10:6]), 32'h1);
    rd(fpl_pkg::OFF_CTRL, 33'h1);
    rd(fpl_pkg::OFF_IRQM, 33'h0);
    rd(12'h040, 33'h1_0000_0000);
    $display("test reset done");
    can_tx_active <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = $urandom();
      dio_state <= a[3:0];
      wt(2);
      check(32'(lit[3:0]), 32'(a[3:0]));
    end
    // With the enable low the indicators must hold their last state.
    clk_en <= 1'b0;
    dio_state <= ~a[3:0];
    wt(3);
    check(32'(lit[3:0]), 32'(a[3:0]));
    clk_en <= 1'b1;
    a = ~a;
    wt(2);
    check(32'(lit[3:0]), 32'(a[3:0]));
    can_tx_data <= 1'b0;
    wt(2);
    a[0] = lit[4];
    can_tx_data <= 1'b1;
    wt(2);
    check(32'(lit[4] ^ a[0]), 32'h1);
    can_tx_active <= 1'b0;
    wt(2);
    check(32'(lit[4]), 32'h0);
    $display("test channels done");
    wr(fpl_pkg::OFF_IRQM, 32'h1);
    wr(fpl_pkg::OFF_CTRL, 32'(fpl_pkg::MODE_RUN));
    u = $urandom() & 32'hf;
    wr(fpl_pkg::OFF_USER, u);
    app_outputs_ctrl <= 1'b1;
    wt(2);
    check(32'(lit[10:6]), u);
    check(32'(lit[5]), 32'h1);
    rd(fpl_pkg::OFF_USER, {1'b0, u});
    c = $urandom() & 32'h7;
    wr(fpl_pkg::OFF_ERRC, c);
    wr(fpl_pkg::OFF_CTRL, 32'(fpl_pkg::MODE_RUN) | 32'h8);
    wt(2);
    check(32'(lit[10:6]), 32'h10 | c);
    check(32'(irq), 32'h1);
    rd(fpl_pkg::OFF_IRQS, 33'h1);
    wr(fpl_pkg::OFF_IRQS, 32'h1);
    wt(2);
    check(32'(irq), 32'h0);
    $display("test run done");
    for (int i = 0; i < 3; i++) begin
      wr(fpl_pkg::OFF_CTRL, 32'(mode[i]));
      wt(2);
      check(32'({lit[10], lit[8:6]}), 32'(pat[i]));
    end
    check(32'(lit[5]), 32'h0);
    wr(fpl_pkg::OFF_CTRL, 32'(fpl_pkg::MODE_UPD));
    wt(2);
    f0 = flips;
    repeat (16) begin
      @(posedge pclk);
      check(32'({lit[10], lit[7:6]}), 32'h3);
    end
    check(32'(flips[2] - f0[2] > 8'h1), 32'h1);
    wr(fpl_pkg::OFF_CTRL, 32'(fpl_pkg::MODE_DONE));
    wt(2);
    f0 = flips;
    repeat (16) begin
      @(posedge pclk);
      check(32'(lit[8:6] == 3'h0 || lit[8:6] == 3'h7), 32'h1);
    end
    check(32'(flips[0] - f0[0] > 8'h1), 32'h1);
    $display("test modes done");
    wr(fpl_pkg::OFF_IRQM, 32'h4);
    eth_link_pulse <= 1'b1;
    eth_speed_100 <= 1'b1;
    wt(3);
    check(32'(lit[12:11]), 32'h3);
    check(32'(irq), 32'h1);
    wr(fpl_pkg::OFF_IRQS, 32'h7);
    eth_speed_100 <= 1'b0;
    eth_activity <= 1'b1;
    @(posedge pclk);
    eth_activity <= 1'b0;
    f0 = flips;
    wt(12);
    check(32'(lit[12]), 32'h0);
    check(32'(irq), 32'h0);
    check(32'(flips[3] != f0[3]), 32'h1);
    eth_link_pulse <= 1'b0;
    wt(3);
    check(32'(lit[11]), 32'h0);
    $display("test ethernet done");
    results();
  end
endmodule
`default_nettype wire
